// *** ir_timer_pkg.sv ***
// package of constants for the infrared envelope and receive capture timer
// assumes a single clock domain and an AHB-Lite register bus of 32 bits
//
// Notes on behaviour
// - envelope select 01b or 10b drives envelope pin
// - polarity zero: envelope pin shows modulation bit
// - polarity one: envelope pin shows inverted bit
// - carrier pin modulated at 01b, continuous at 10b
// - receive mode when direction zero, unit enabled
// - edge select picks rising, falling or both
// - counter starts from zero at first event
// - counter ticks per carrier or divided clock
// - later events load modulation bit with level
// - standard receive copies counter into time register
// - reload bit clears counter on each event
// - counter wrap without a same-tick event sets overflow flag, interrupt only with event interrupt enable
// - receive runs until transmit chosen or disabled
// - burst mode counts edges, no capture
// - burst mode flags two carrier periods silent
// - burst mode rising preset time register one
// - burst mode keeps clock select and reload
// - carrier high count plus one, low plus one
// - polarity sets idle level and carrier inversion

package ir_timer_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] control_off = 8'h00;
   localparam logic [7:0] carrier_off = 8'h04;
   localparam logic [7:0] modtime_off = 8'h08;
   localparam logic [7:0] value_off = 8'h0c;
   localparam logic [7:0] status_off = 8'h10;

   // ----------------------------------------------------------------
   // control and status field positions
   // ----------------------------------------------------------------
   localparam int unit_enable_pos = 0;
   localparam int direction_select_pos = 1;
   localparam int counter_clock_select_pos = 2;
   localparam int capture_reload_enable_pos = 3;
   localparam int burst_count_mode_pos = 4;
   localparam int transmit_polarity_pos = 5;
   localparam int modulation_bit_pos = 6;
   localparam int event_interrupt_enable_pos = 7;
   localparam int edge_select_lsb = 8;
   localparam int envelope_output_select_lsb = 10;
   localparam int divider_lsb = 12;
   localparam int event_flag_pos = 0;
   localparam int overflow_flag_pos = 1;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] env_off = 2'h0;
   localparam logic [1:0] env_modulated = 2'h1;
   localparam logic [1:0] env_continuous = 2'h2;
   localparam logic [1:0] edge_rising = 2'h1;
   localparam logic [1:0] edge_falling = 2'h2;
   localparam logic [1:0] edge_both = 2'h3;
   localparam logic [15:0] control_rst = 16'h0000;
   localparam logic [15:0] carrier_rst = 16'h0000;
   localparam logic [15:0] modtime_rst = 16'h0000;
   localparam logic [15:0] counter_zero = 16'h0000;
   localparam logic [15:0] counter_max = 16'hffff;
   localparam logic [15:0] burst_preset = 16'h0001;
   localparam logic [1:0] silent_periods = 2'h2;
   localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage : ir_timer_pkg

// *** ir_timer.sv ***
// infrared timer: transmit envelope output and receive edge capture
// assumes an AHB-Lite master on hclk and an asynchronous receive pin
`timescale 1ns/1ps

module ir_timer
   import ir_timer_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // asynchronous reset, active low
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic receive_in_pin, // infrared receiver input
   output logic carrier_out_pin, // carrier output
   output logic envelope_out_pin, // envelope output
   output logic ir_irq // event or overflow request
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [15:0] control_reg, carrier_period_reg;
   logic [15:0] modulator_time_reg, timer_value_counter;
   logic event_flag, overflow_flag, modulation_bit;

   logic unit_enable, direction_select, counter_clock_select;
   logic capture_reload_enable, burst_count_mode, transmit_polarity;
   logic event_interrupt_enable;
   logic [1:0] edge_select, envelope_output_select;
   logic [2:0] divider_sel;

   assign unit_enable = control_reg[unit_enable_pos];
   assign direction_select = control_reg[direction_select_pos];
   assign counter_clock_select = control_reg[counter_clock_select_pos];
   assign capture_reload_enable = control_reg[capture_reload_enable_pos];
   assign burst_count_mode = control_reg[burst_count_mode_pos];
   assign transmit_polarity = control_reg[transmit_polarity_pos];
   assign event_interrupt_enable = control_reg[event_interrupt_enable_pos];
   assign edge_select = control_reg[edge_select_lsb +: 2];
   assign envelope_output_select = control_reg[envelope_output_select_lsb +: 2];
   assign divider_sel = control_reg[divider_lsb +: 3];

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic wr_pend_reg, rd_wait_reg, take, wr_strobe;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg, read_mux;
   logic [15:0] wdata;

   assign take = hsel & hready & (htrans == htrans_nonseq);
   assign wr_strobe = wr_pend_reg;
   assign wdata = hwdata[15:0];
   assign hresp = 1'b0;
   assign hreadyout = ~rd_wait_reg;
   assign hrdata = hrdata_reg;

   // address phase capture; reads insert one wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         if (rd_wait_reg) begin
            rd_wait_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
         end else begin
            wr_pend_reg <= take & hwrite;
            rd_wait_reg <= take & ~hwrite;
            if (take) begin
               addr_reg <= haddr;
            end
         end
      end
   end

   // read multiplexer, unmapped reads return zero
   always_comb begin
      read_mux = 32'h0000_0000;
      case (addr_reg)
         control_off: begin
            read_mux[15:0] = control_reg;
            read_mux[modulation_bit_pos] = modulation_bit;
         end
         carrier_off: read_mux[15:0] = carrier_period_reg;
         modtime_off: read_mux[15:0] = modulator_time_reg;
         value_off: read_mux[15:0] = timer_value_counter;
         status_off: begin
            read_mux[event_flag_pos] = event_flag;
            read_mux[overflow_flag_pos] = overflow_flag;
         end
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // read data taken in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_wait_reg) begin
         hrdata_reg <= read_mux;
      end
   end

   // control and carrier registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_reg <= control_rst;
         carrier_period_reg <= carrier_rst;
      end else if (wr_strobe) begin
         if (addr_reg == control_off) begin
            control_reg <= wdata;
         end
         if (addr_reg == carrier_off) begin
            carrier_period_reg <= wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   logic tx_active, rx_active, tx_active_q, burst_q;
   logic tx_start, burst_rise;

   assign tx_active = unit_enable & direction_select;
   assign rx_active = unit_enable & ~direction_select;
   assign tx_start = tx_active & ~tx_active_q;
   assign burst_rise = burst_count_mode & ~burst_q;

   // previous mode levels for start detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_active_q <= 1'b0;
         burst_q <= 1'b0;
      end else begin
         tx_active_q <= tx_active;
         burst_q <= burst_count_mode;
      end
   end

   // ----------------------------------------------------------------
   // prescaler and carrier generator
   // ----------------------------------------------------------------
   logic [6:0] div_cnt_reg, div_limit;
   logic [15:0] carrier_lat_reg;
   logic [7:0] phase_cnt_reg, phase_limit;
   logic div_tick, phase_high_reg, carrier_tick, count_tick;

   assign div_limit = 7'((8'h01 << divider_sel) - 8'h01);
   assign div_tick = unit_enable & (div_cnt_reg == div_limit);
   assign phase_limit = phase_high_reg ? carrier_lat_reg[15:8]
                                       : carrier_lat_reg[7:0];
   assign carrier_tick = div_tick & ~phase_high_reg &
                         (phase_cnt_reg == phase_limit);
   assign count_tick = counter_clock_select ? div_tick : carrier_tick;

   // divided input clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg <= 7'h00;
      end else if (!unit_enable || div_tick) begin
         div_cnt_reg <= 7'h00;
      end else begin
         div_cnt_reg <= div_cnt_reg + 7'h01;
      end
   end

   // high for high count plus one, low for low count plus one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_cnt_reg <= 8'h00;
         phase_high_reg <= 1'b1;
      end else if (!unit_enable || tx_start) begin
         phase_cnt_reg <= 8'h00;
         phase_high_reg <= 1'b1;
      end else if (div_tick) begin
         if (phase_cnt_reg == phase_limit) begin
            phase_cnt_reg <= 8'h00;
            phase_high_reg <= ~phase_high_reg;
         end else begin
            phase_cnt_reg <= phase_cnt_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // receive pin synchroniser and edge qualifier
   // ----------------------------------------------------------------
   logic rx_s1, rx_s2, rx_s3, rx_level;
   logic rx_change, rx_rise, rx_fall, qual_edge;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_s3 <= 1'b0;
         rx_level <= 1'b0;
      end else begin
         rx_s1 <= receive_in_pin;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_level <= rx_s3;
         end
      end
   end

   assign rx_change = (rx_s2 == rx_s3) & (rx_s3 != rx_level);
   assign rx_rise = rx_change & rx_s3;
   assign rx_fall = rx_change & ~rx_s3;

   // pick qualifying transitions
   always_comb begin
      case (edge_select)
         edge_rising: qual_edge = rx_rise;
         edge_falling: qual_edge = rx_fall;
         edge_both: qual_edge = rx_change;
         default: qual_edge = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // receive sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {rx_idle, rx_wait_first, rx_run} rx_state_t;
   rx_state_t rx_state_reg;
   logic rx_event, rx_first, silent_hit;
   logic [1:0] silent_cnt_reg;

   assign rx_first = (rx_state_reg == rx_wait_first) & qual_edge;
   assign rx_event = (rx_state_reg == rx_run) & qual_edge;
   assign silent_hit = rx_active & burst_count_mode & carrier_tick &
                       (rx_state_reg == rx_run) & ~qual_edge &
                       (silent_cnt_reg == silent_periods);

   // receive state machine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_state_reg <= rx_idle;
      end else begin
         case (rx_state_reg)
            rx_idle: begin
               if (rx_active) begin
                  rx_state_reg <= rx_wait_first;
               end
            end
            rx_wait_first: begin
               if (!rx_active) begin
                  rx_state_reg <= rx_idle;
               end else if (qual_edge) begin
                  rx_state_reg <= rx_run;
               end
            end
            rx_run: begin
               if (!rx_active) begin
                  rx_state_reg <= rx_idle;
               end
            end
            default: rx_state_reg <= rx_idle;
         endcase
      end
   end

   // carrier periods without an edge, counted once per space
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         silent_cnt_reg <= 2'h0;
      end else if (qual_edge || !rx_active) begin
         silent_cnt_reg <= 2'h0;
      end else if (carrier_tick && !(&silent_cnt_reg)) begin
         silent_cnt_reg <= silent_cnt_reg + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // timer value counter
   // ----------------------------------------------------------------
   logic tx_reload, rx_wrap;

   assign tx_reload = tx_active & ~tx_start & count_tick &
                      (timer_value_counter == counter_zero);
   assign rx_wrap = (rx_state_reg == rx_run) & count_tick & ~rx_event &
                    (timer_value_counter == counter_max);

   // down count in transmit, up count in receive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_value_counter <= counter_zero;
      end else if (tx_start || tx_reload) begin
         timer_value_counter <= modulator_time_reg;
      end else if (tx_active && count_tick) begin
         timer_value_counter <= timer_value_counter - 16'h0001;
      end else if (rx_active) begin
         if (rx_first) begin
            timer_value_counter <= counter_zero;
         end else if (rx_event && capture_reload_enable) begin
            timer_value_counter <= counter_zero;
         end else if (rx_state_reg == rx_run && count_tick) begin
            timer_value_counter <= timer_value_counter + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // modulator time register and modulation bit
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modulator_time_reg <= modtime_rst;
      end else if (burst_rise) begin
         modulator_time_reg <= burst_preset;
      end else if (rx_event && burst_count_mode) begin
         modulator_time_reg <= modulator_time_reg + 16'h0001;
      end else if (rx_event) begin
         modulator_time_reg <= timer_value_counter;
      end else if (wr_strobe && addr_reg == modtime_off) begin
         modulator_time_reg <= wdata;
      end
   end

   // hardware load on receive events wins over software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modulation_bit <= 1'b0;
      end else if (rx_event) begin
         modulation_bit <= rx_rise;
      end else if (wr_strobe && addr_reg == control_off) begin
         modulation_bit <= wdata[modulation_bit_pos];
      end
   end

   // ----------------------------------------------------------------
   // status flags, write one to clear, setting wins
   // ----------------------------------------------------------------
   logic event_set, clr_event, clr_over;

   assign event_set = tx_reload |
                      (rx_event & ~burst_count_mode) | silent_hit;
   assign clr_event = wr_strobe & (addr_reg == status_off) &
                      wdata[event_flag_pos];
   assign clr_over = wr_strobe & (addr_reg == status_off) &
                     wdata[overflow_flag_pos];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_flag <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         if (event_set) begin
            event_flag <= 1'b1;
         end else if (clr_event) begin
            event_flag <= 1'b0;
         end
         if (rx_wrap) begin
            overflow_flag <= 1'b1;
         end else if (clr_over) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   assign ir_irq = event_interrupt_enable & (event_flag | overflow_flag);

   // ----------------------------------------------------------------
   // transmit sampling and pin outputs
   // ----------------------------------------------------------------
   logic data_lat_reg, pol_lat_reg, carrier_wave;
   logic carrier_next, envelope_next, carrier_pin_reg, envelope_pin_reg;

   // carrier, bit and polarity sampled at each interval boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_lat_reg <= carrier_rst;
         data_lat_reg <= 1'b0;
         pol_lat_reg <= 1'b0;
      end else if (!tx_active || tx_start || tx_reload) begin
         carrier_lat_reg <= carrier_period_reg;
         data_lat_reg <= modulation_bit;
         pol_lat_reg <= transmit_polarity;
      end
   end

   assign carrier_wave = phase_high_reg ^ pol_lat_reg;

   always_comb begin
      carrier_next = 1'b0;
      envelope_next = 1'b0;
      if (tx_active && !tx_start) begin
         envelope_next = data_lat_reg ^ pol_lat_reg;
         case (envelope_output_select)
            env_continuous: carrier_next = carrier_wave;
            default: carrier_next = data_lat_reg ? carrier_wave
                                                 : pol_lat_reg;
         endcase
         if (envelope_output_select == env_off ||
             envelope_output_select == edge_both) begin
            envelope_next = 1'b0;
         end
      end else if (unit_enable) begin
         carrier_next = transmit_polarity;
      end
   end

   // registered pin drivers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_pin_reg <= 1'b0;
         envelope_pin_reg <= 1'b0;
      end else begin
         carrier_pin_reg <= carrier_next;
         envelope_pin_reg <= envelope_next;
      end
   end

   assign carrier_out_pin = carrier_pin_reg;
   assign envelope_out_pin = envelope_pin_reg;

   logic unused_ok;
   assign unused_ok = ^{hsize, hwdata[31:16]};

endmodule : ir_timer

// *** ir_timer_assertions.sv ***
// checker of bus timing and pin levels of the infrared timer
// assumes it is bound to ir_timer and sees only its ports
`timescale 1ns/1ps

module ir_timer_assertions
   import ir_timer_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // reset, active low
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic [31:0] hrdata, // read data
   input wire logic carrier_out_pin, // carrier output
   input wire logic envelope_out_pin, // envelope output
   input wire logic ir_irq // request line
);
   logic [15:0] ctl;
   logic wr_ph;
   logic [7:0] wr_a;

   // --------------------------------------------------------------
   // shadow of the control word, taken from completed writes
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         wr_a <= 8'h00;
         ctl <= control_rst;
      end else if (hready) begin
         if (wr_ph && wr_a == control_off) ctl <= hwdata[15:0];
         wr_ph <= hsel && htrans == htrans_nonseq && hwrite;
         wr_a <= haddr;
      end
   end

   // --------------------------------------------------------------
   // properties
   // --------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_req;
      hsel && hready && htrans == htrans_nonseq && !hwrite;
   endsequence
   sequence wr_req;
      hsel && hready && htrans == htrans_nonseq && hwrite;
   endsequence
   sequence rx_on;
      (ctl[unit_enable_pos] && !ctl[direction_select_pos]) [*3];
   endsequence
   a_read_one_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (wr_req |=> hreadyout)
      else $error("write data phase stalled");
   a_unmapped_zero: assert property (rd_req and haddr > status_off
      |-> ##2 hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_off_pins_low: assert property ((!ctl[unit_enable_pos]) [*3]
      |-> !carrier_out_pin && !envelope_out_pin)
      else $error("pins not low while off");
   a_env_pin_off: assert property ((ctl[unit_enable_pos] &&
      (ctl[11:10] == env_off || ctl[11:10] == 2'h3)) [*3] |-> !envelope_out_pin)
      else $error("envelope pin active unselected");
   a_rx_idle_level: assert property (rx_on
      |-> carrier_out_pin == ctl[transmit_polarity_pos])
      else $error("carrier pin not idle in receive");
   a_irq_masked: assert property (!ctl[event_interrupt_enable_pos]
      |-> !ir_irq)
      else $error("request while masked");
endmodule : ir_timer_assertions

bind ir_timer ir_timer_assertions chk_u (.*);

// *** ir_timer_partner.sv ***
// receiver and emitter model: square wave source, carrier run meter
// assumes the bench steers it through run, hi_n and lo_n
`timescale 1ns/1ps

module ir_timer_partner (
   input wire logic hclk, // system clock
   input wire logic run, // wave on while high
   input wire logic [7:0] hi_n, // cycles high
   input wire logic [7:0] lo_n, // cycles low
   input wire logic carrier_out_pin, // carrier seen
   output logic receive_in_pin, // receiver output
   output logic [15:0] n_rise, // rising edges sent
   output logic [7:0] hi_len, // last high run
   output logic [7:0] lo_len // last low run
);
   logic [7:0] cnt;
   logic [7:0] run_len;
   logic last;

   initial begin
      {receive_in_pin, last, cnt, n_rise, hi_len, lo_len} = '0;
      run_len = 8'h01;
   end

   // square wave, the receiver holds its level while stopped
   always @(posedge hclk) begin
      if (!run) cnt <= 8'h00;
      else if (cnt >= (receive_in_pin ? hi_n : lo_n) - 8'h01) begin
         cnt <= 8'h00;
         receive_in_pin <= !receive_in_pin;
         if (!receive_in_pin) n_rise <= n_rise + 16'h0001;
      end else cnt <= cnt + 8'h01;
   end

   // length of each carrier level in clocks
   always @(posedge hclk) begin
      last <= carrier_out_pin;
      if (carrier_out_pin == last) run_len <= run_len + 8'h01;
      else begin
         run_len <= 8'h01;
         if (last) hi_len <= run_len;
         else lo_len <= run_len;
      end
   end
endmodule : ir_timer_partner

// *** test_ir_timer.sv ***
// bench of the infrared timer: bus tasks and directed sequences
// assumes the partner model on the pins and the bound checker
`timescale 1ns/1ps

module test_ir_timer;
   import ir_timer_pkg::*;
   logic hclk, hresetn, hsel, hwrite, run, hreadyout, hresp;
   logic receive_in_pin, carrier_out_pin, envelope_out_pin, ir_irq;
   logic [7:0] haddr, hi_n, lo_n, hi_len, lo_len;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, q, m1;
   logic [15:0] n_rise, n0;
   int error_cnt = 0;
   int n_tests = 0;
   logic [15:0] tx_ctl [4] = '{16'h0403, 16'h0843, 16'h0863, 16'h0803};
   logic tx_env [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
   logic [15:0] tx_len [4] = '{16'h0000, 16'h0403, 16'h0304, 16'h0403};
   logic [15:0] rx_ctl [4] = '{16'h010d, 16'h010d, 16'h030d, 16'h0209};
   logic [7:0] rx_hi [4] = '{8'h14, 8'h1e, 8'h14, 8'h1e};
   logic [7:0] rx_lo [4] = '{8'h14, 8'h22, 8'h14, 8'h22};
   logic [15:0] rx_cap [4] = '{16'h0027, 16'h003f, 16'h0013, 16'h0009};

   ir_timer dut_u (.hready(hreadyout), .*);
   ir_timer_partner ir_u (.*);

   always #5 hclk = ~hclk;

   // --------------------------------------------------------------
   // bus cycles, compare and close
   // --------------------------------------------------------------
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= htrans_nonseq;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(a, 1'b0, 32'h0000_0000, r);
   endtask : rd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // --------------------------------------------------------------
   // sequences
   // --------------------------------------------------------------
   initial begin
      {hclk, hresetn, hsel, hwrite, run, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      hi_n = 8'h05;
      lo_n = 8'h05;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      wr(value_off, 32'h0000_1234);
      for (int i = 0; i < 6; i++) begin
         rd(8'(4 * i), q);
         check(q, 32'h0000_0000);
      end
      $display("test reset values done");
      wr(carrier_off, 32'h0000_0302);
      wr(modtime_off, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         wr(control_off, {16'h0000, tx_ctl[i]});
         repeat (80) @(posedge hclk);
         check(envelope_out_pin, tx_env[i]);
         check({hi_len, lo_len}, tx_len[i]);
      end
      $display("test transmit envelope done");
      wr(control_off, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         hi_n <= rx_hi[i];
         lo_n <= rx_lo[i];
         run <= 1'b1;
         wr(control_off, {16'h0000, rx_ctl[i]});
         repeat (200) @(posedge hclk);
         rd(modtime_off, q);
         check(q, {16'h0000, rx_cap[i]});
         rd(control_off, q);
         if (i != 2) check(q[6], i != 3);
      end
      wr(control_off, 32'h0000_0105);
      repeat (200) @(posedge hclk);
      rd(value_off, q);
      check(q > 32'd150, 1'b1);
      wr(control_off, 32'h0000_0104);
      rd(value_off, m1);
      repeat (50) @(posedge hclk);
      rd(value_off, q);
      check(q, m1);
      $display("test receive capture done");
      run <= 1'b0;
      hi_n <= 8'h05;
      lo_n <= 8'h05;
      wr(control_off, 32'h0000_0000);
      wr(control_off, 32'h0000_019d);
      rd(modtime_off, q);
      check(q, 32'h0000_0001);
      wr(status_off, 32'h0000_0003);
      n0 = n_rise;
      run <= 1'b1;
      repeat (100) @(posedge hclk);
      rd(status_off, q);
      check(q, 32'h0000_0000);
      run <= 1'b0;
      repeat (40) @(posedge hclk);
      rd(modtime_off, q);
      check(q, {16'h0000, n_rise - n0});
      rd(status_off, q);
      check(q[0], 1'b1);
      check(ir_irq, 1'b1);
      wr(status_off, 32'h0000_0003);
      rd(status_off, q);
      check(q, 32'h0000_0000);
      check(ir_irq, 1'b0);
      $display("test burst count done");
      wr(control_off, 32'h0000_0000);
      wr(control_off, 32'h0000_0185);
      run <= 1'b1;
      repeat (20) @(posedge hclk);
      run <= 1'b0;
      repeat (66000) @(posedge hclk);
      rd(status_off, q);
      check(q[1], 1'b1);
      check(ir_irq, 1'b1);
      $display("test overflow done");
      end_sim;
   end

   // watchdog against a hung handshake
   initial begin
      #900_000;
      error_cnt++;
      end_sim;
   end
endmodule : test_ir_timer
